// ===== rtl/dmac_six_ch.sv
`timescale 1ns/1ps
`default_nettype none
`include "dmac_map.svh"
// Behaviour
// RL1 - six independent channels, each serving requests from its peripherals.
// RL2 - each channel starts on its hardware request lines or a software trigger.
// RL3 - per-channel high or default priority; high wins arbitration.
// RL4 - memory-to-memory and offload-memory transfers are started by software only.
// RL5 - channels 1-4 take sync port 0/1 and serial 0/1 requests; 5,6 none.
// RL6 - serial and sync port channels start on hardware or software request.
// RL7 - any bus address (flash, SRAM, peripherals) may be source or destination.
// RL8 - four-bit exponent R: re-arbitrate after every 2^R transfers.
// RL9 - full 2^R bursts first, leftover transfers at the end.
// RL10 - software avoids large R on low-priority channels.
// RL11 - cycle type field selects invalid, basic, auto-request or ping-pong.
// RL12 - completed cycle writes invalid type back into its structure.
// RL13 - basic: on request do 2^R transfers, finish when none remain.
// RL14 - basic: after a burst arbitrate; continue only on a new request.
// RL15 - completion pulses the channel's done output for one clock.
// RL16 - auto-request: one request completes the whole cycle.
// RL17 - auto-request: after a burst re-arbitrate and continue if still highest.
// RL18 - ping-pong alternates structures until invalid, basic, or disabled.
// RL19 - idle ping-pong structure may be rewritten and starts next.
// RL20 - unreprogrammed idle structure reads invalid and ends ping-pong.
// RL21 - fetch control structure over the bus; write back count and type.
// RL22 - requests on disabled channels are ignored; no transfer, no done.
module dmac_six_ch (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [5:0]  ch_enable,
  input  wire logic [5:0]  ch_high_prio,
  input  wire logic [5:0]  ch_alt_select,
  input  wire logic [5:0]  sw_request,
  input  wire logic        sync_port0_tx_request,
  input  wire logic        sync_port0_rx_request,
  input  wire logic        sync_port1_tx_request,
  input  wire logic        sync_port1_rx_request,
  input  wire logic        serial0_tx_request,
  input  wire logic        serial0_rx_request,
  input  wire logic        serial1_tx_request,
  input  wire logic        serial1_rx_request,
  input  wire logic [31:0] ctrl_base,
  output logic             bus_req,
  output logic             bus_we,
  output logic [31:0]      bus_addr,
  output logic [31:0]      bus_wdata,
  input  wire logic [31:0] bus_rdata,
  input  wire logic        bus_ack,
  output logic [5:0]       dma_done,
  output logic [5:0]       ch_alt_active,
  output logic             busy,
  output logic [2:0]       active_ch
);
  import dmac_pkg::*;

  dmac_core_t  q;
  dmac_core_t  n;
  logic [5:0]  hw_req;
  logic [5:0]  req_in;
  logic [5:0]  clr;
  logic [5:0]  self_set;
  logic [3:0]  pick_hi;
  logic [3:0]  pick_any;
  logic [2:0]  gch;
  logic [2:0]  cc_rd;
  logic [10:0] rem_rd;
  logic [15:0] pow_rd;

  dmac_buf_if bif ();

  dmac_fifo2 u_buf (
    .clk (clk),
    .rst (rst),
    .bi  (bif.buf_side)
  );

  // structure address: alternate set sits 0x80 above the primary set
  function automatic logic [31:0] struct_addr(input logic [31:0] base, input logic alt,
                                              input logic [2:0] ch, input logic [3:0] ofs);
    struct_addr = base + {24'h0, alt, ch, ofs};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // fixed request wiring; channels 5 and 6 only see software
  assign hw_req = {2'b00,
                   serial1_tx_request | serial1_rx_request,
                   serial0_tx_request | serial0_rx_request,
                   sync_port1_tx_request | sync_port1_rx_request,
                   sync_port0_tx_request | sync_port0_rx_request}; // RL5
  assign req_in = hw_req | sw_request; // RL2 RL6

  // high priority first, lowest channel index breaks ties
  assign pick_hi = dmac_pick(q.pend & ch_enable & ch_high_prio); // RL3
  assign pick_any = dmac_pick(q.pend & ch_enable);
  assign gch = pick_hi[3] ? pick_hi[2:0] : pick_any[2:0];

  // fields of the control word as it arrives from memory
  assign cc_rd = bus_rdata[`DMAC_CC_MSB:`DMAC_CC_LSB];
  assign rem_rd = {1'b0, bus_rdata[`DMAC_N_MSB:`DMAC_N_LSB]} + 11'h1;
  assign pow_rd = 16'h1 << bus_rdata[`DMAC_R_MSB:`DMAC_R_LSB]; // RL8

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic for the whole engine
  always_comb begin
    n = q;
    n.done = 6'h0;
    clr = 6'h0;
    self_set = 6'h0;
    bif.in_valid = 1'b0;
    bif.in_data = bus_rdata;
    bif.out_ready = 1'b0;
    unique case (q.st)
      ST_IDLE: begin
        if (pick_any[3]) begin // RL1
          n.ch = gch;
          clr[gch] = 1'b1;
          n.st = ST_FCTL;
          n.bus_req = 1'b1;
          n.bus_we = 1'b0;
          n.bus_addr = struct_addr(ctrl_base, q.alt[gch], gch, `DMAC_OFS_CTL); // RL21
        end
      end
      ST_FCTL: begin
        if (bus_ack) begin
          n.bus_req = 1'b0;
          n.ctl = bus_rdata;
          // unknown codes are handled as invalid: nothing runs, no done
          if (cc_rd == `DMAC_CC_INVALID || cc_rd > `DMAC_CC_PINGPONG) begin // RL11 RL20
            n.st = ST_IDLE;
          end else begin
            n.st = ST_FSRC;
            n.rd_rem = rem_rd;
            n.wr_rem = rem_rd;
            n.rd_left = ({5'h0, rem_rd} < pow_rd) ? {5'h0, rem_rd} : pow_rd; // RL9
            n.wr_left = ({5'h0, rem_rd} < pow_rd) ? {5'h0, rem_rd} : pow_rd;
            n.bus_req = 1'b1;
            n.bus_addr = struct_addr(ctrl_base, q.alt[q.ch], q.ch, `DMAC_OFS_SRC); // RL21
          end
        end
      end
      ST_FSRC: begin
        if (bus_ack) begin
          n.src_end = bus_rdata;
          n.st = ST_FDST;
          n.bus_addr = struct_addr(ctrl_base, q.alt[q.ch], q.ch, `DMAC_OFS_DST);
        end
      end
      ST_FDST: begin
        if (bus_ack) begin
          n.bus_req = 1'b0;
          n.dst_end = bus_rdata;
          n.st = ST_XFER;
        end
      end
      ST_XFER: begin
        // reads run ahead into the buffer; a slow write stalls further reads
        if (q.bus_req) begin
          if (bus_ack) begin
            n.bus_req = 1'b0;
            bif.in_valid = !q.bus_we;
          end
        end else if (q.rd_left != 16'h0 && bif.in_ready) begin
          n.bus_req = 1'b1;
          n.bus_we = 1'b0;
          n.bus_addr = q.ctl[`DMAC_SINC_BIT] ?
                       q.src_end - {19'h0, q.rd_rem - 11'h1, 2'b00} : q.src_end; // RL7
          n.rd_left = q.rd_left - 16'h1;
          n.rd_rem = q.rd_rem - 11'h1;
        end else if (bif.out_valid) begin
          bif.out_ready = 1'b1;
          n.bus_req = 1'b1;
          n.bus_we = 1'b1;
          n.bus_wdata = bif.out_data;
          n.bus_addr = q.ctl[`DMAC_DINC_BIT] ?
                       q.dst_end - {19'h0, q.wr_rem - 11'h1, 2'b00} : q.dst_end; // RL7
          n.wr_left = q.wr_left - 16'h1;
          n.wr_rem = q.wr_rem - 11'h1;
        end else if (q.wr_left == 16'h0) begin
          // burst over: store remaining count and, when finished, invalid type
          n.st = ST_WBCTL;
          n.bus_req = 1'b1;
          n.bus_we = 1'b1;
          n.bus_addr = struct_addr(ctrl_base, q.alt[q.ch], q.ch, `DMAC_OFS_CTL); // RL21
          n.bus_wdata = q.ctl;
          n.bus_wdata[`DMAC_N_MSB:`DMAC_N_LSB] = (q.wr_rem == 11'h0) ?
                                                 10'h0 : 10'(q.wr_rem - 11'h1);
          if (q.wr_rem == 11'h0) begin
            n.bus_wdata[`DMAC_CC_MSB:`DMAC_CC_LSB] = `DMAC_CC_INVALID; // RL12
          end
        end
      end
      ST_WBCTL: begin
        if (bus_ack) begin
          n.bus_req = 1'b0;
          n.st = ST_IDLE;
          if (q.wr_rem == 11'h0) begin
            n.done[q.ch] = 1'b1; // RL13 RL15
            if (q.ctl[`DMAC_CC_MSB:`DMAC_CC_LSB] == `DMAC_CC_PINGPONG) begin
              // swap to the other structure and re-queue the channel at once
              n.alt[q.ch] = ~q.alt[q.ch]; // RL18
              self_set[q.ch] = 1'b1; // RL19
            end
          end else if (q.ctl[`DMAC_CC_MSB:`DMAC_CC_LSB] == `DMAC_CC_AUTO) begin
            self_set[q.ch] = 1'b1; // RL16 RL17
          end
          // basic and ping-pong mid-cycle wait for a fresh request here
        end // RL14
      end
    endcase
    // a request in the grant cycle survives the clear; disabled drops all
    n.pend = ((q.pend & ~clr) | req_in | self_set) & ch_enable; // RL22 RL2
    // structure choice follows software while the channel is off
    for (int i = 0; i < `DMAC_NCH; i++) begin
      if (!ch_enable[i]) begin
        n.alt[i] = ch_alt_select[i]; // RL18
      end
    end
    n.busy = (n.st != ST_IDLE);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // every output is a field of the state register
  assign bus_req = q.bus_req;
  assign bus_we = q.bus_we;
  assign bus_addr = q.bus_addr;
  assign bus_wdata = q.bus_wdata;
  assign dma_done = q.done;
  assign ch_alt_active = q.alt;
  assign busy = q.busy;
  assign active_ch = q.ch;

  ////////////////////////////////////////////////////////////////////////////
  // checks on the engine
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_done_one_cycle : assert property ( // RL15
    |dma_done |=> dma_done == 6'h0) else $error("done wider than one clock");

  a_done_after_wb : assert property ( // RL12
    |dma_done |-> $past(q.st == ST_WBCTL && bus_ack && q.wr_rem == 11'h0))
    else $error("done without final writeback");

  a_wb_invalid : assert property ( // RL12
    (q.st == ST_WBCTL && q.wr_rem == 11'h0) |->
      bus_wdata[`DMAC_CC_MSB:`DMAC_CC_LSB] == `DMAC_CC_INVALID)
    else $error("final writeback not invalid");

  a_grant_enabled : assert property ( // RL22
    (q.st == ST_FCTL && $past(q.st) == ST_IDLE) |->
      (($past(ch_enable) >> q.ch) & 6'h1) != 6'h0) else $error("disabled channel granted");

  a_high_prio_first : assert property ( // RL3
    (q.st == ST_IDLE && |(q.pend & ch_enable & ch_high_prio)) |=>
      (q.st == ST_FCTL && (($past(ch_high_prio) >> q.ch) & 6'h1) != 6'h0))
    else $error("default channel beat high channel");

  a_burst_bound : assert property ( // RL8
    q.st == ST_XFER |-> q.rd_left <= (16'h1 << q.ctl[`DMAC_R_MSB:`DMAC_R_LSB]))
    else $error("burst longer than 2^R");

  a_sw_req_held : assert property ( // RL2
    |(sw_request & ch_enable) |=> (q.pend & $past(sw_request & ch_enable)) != 6'h0)
    else $error("software request lost");

  a_serial0_maps : assert property ( // RL5
    (serial0_rx_request && ch_enable[2]) |=> q.pend[2]) else $error("serial0 not on ch3");

  a_auto_rearb : assert property ( // RL17
    (q.st == ST_WBCTL && bus_ack && q.wr_rem != 11'h0 &&
     q.ctl[`DMAC_CC_MSB:`DMAC_CC_LSB] == `DMAC_CC_AUTO && ch_enable[q.ch]) |=>
      q.st == ST_IDLE ##1 q.st == ST_FCTL) else $error("auto cycle did not continue");

  // a stalled bus request must not move under the memory's feet
  a_bus_hold : assert property ( // RL21
    (bus_req && !bus_ack) |=> (bus_req && $stable(bus_addr) && $stable(bus_we) &&
      $stable(bus_wdata))) else $error("bus request changed before ack");

  // invalid and unknown cycle codes end the grant without any data traffic
  a_invalid_idle : assert property ( // RL11 RL20
    (q.st == ST_FCTL && bus_ack &&
     (cc_rd == `DMAC_CC_INVALID || cc_rd > `DMAC_CC_PINGPONG)) |=>
      (q.st == ST_IDLE && !bus_req)) else $error("invalid structure started a transfer");

  // a finished ping-pong half queues the other structure straight away
  a_pp_repend : assert property ( // RL19
    (q.st == ST_WBCTL && bus_ack && q.wr_rem == 11'h0 && ch_enable[q.ch] &&
     q.ctl[`DMAC_CC_MSB:`DMAC_CC_LSB] == `DMAC_CC_PINGPONG) |=>
      ((q.pend >> $past(q.ch)) & 6'h1) != 6'h0) else $error("ping-pong did not re-queue");

  c_done_seen : cover property (|dma_done);
  c_pingpong_swap : cover property (q.st == ST_WBCTL && bus_ack && q.wr_rem == 11'h0 &&
                                    q.ctl[`DMAC_CC_MSB:`DMAC_CC_LSB] == `DMAC_CC_PINGPONG);
  c_auto_burst : cover property (q.st == ST_WBCTL && q.wr_rem != 11'h0 &&
                                 q.ctl[`DMAC_CC_MSB:`DMAC_CC_LSB] == `DMAC_CC_AUTO);
endmodule
`default_nettype wire

// ===== common/dmac_map.svh
`ifndef DMAC_MAP_SVH
`define DMAC_MAP_SVH

// channel count and buffer depth
`define DMAC_NCH          6
`define DMAC_BUF_DEPTH    2'h2

// cycle type codes held in the control word
`define DMAC_CC_INVALID   3'h0
`define DMAC_CC_BASIC     3'h1
`define DMAC_CC_AUTO      3'h2
`define DMAC_CC_PINGPONG  3'h3

// control word field positions
`define DMAC_CC_LSB       0
`define DMAC_CC_MSB       2
`define DMAC_N_LSB        4
`define DMAC_N_MSB        13
`define DMAC_R_LSB        14
`define DMAC_R_MSB        17
`define DMAC_SINC_BIT     18
`define DMAC_DINC_BIT     19

// control structure layout in system memory
`define DMAC_OFS_SRC      4'h0
`define DMAC_OFS_DST      4'h4
`define DMAC_OFS_CTL      4'h8

`endif

// ===== common/dmac_pkg.sv
package dmac_pkg;

  typedef enum logic [2:0] {
    ST_IDLE, ST_FCTL, ST_FSRC, ST_FDST, ST_XFER, ST_WBCTL
  } dmac_state_t;

  typedef struct packed {
    dmac_state_t st;
    logic [2:0]  ch;
    logic [5:0]  pend;
    logic [5:0]  alt;
    logic [5:0]  done;
    logic        busy;
    logic [31:0] ctl;
    logic [31:0] src_end;
    logic [31:0] dst_end;
    logic [10:0] rd_rem;
    logic [10:0] wr_rem;
    logic [15:0] rd_left;
    logic [15:0] wr_left;
    logic        bus_req;
    logic        bus_we;
    logic [31:0] bus_addr;
    logic [31:0] bus_wdata;
  } dmac_core_t;

  typedef struct packed {
    logic [1:0][31:0] mem;
    logic             wp;
    logic             rp;
    logic [1:0]       cnt;
  } dmac_fifo_t;

  // lowest set bit wins; returns {found, index}
  function automatic logic [3:0] dmac_pick(input logic [5:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 5; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction

endpackage

// ===== common/dmac_buf_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dmac_buf_if;
  logic        in_valid;
  logic        in_ready;
  logic [31:0] in_data;
  logic        out_valid;
  logic        out_ready;
  logic [31:0] out_data;

  modport buf_side (input in_valid, input in_data, input out_ready,
                    output in_ready, output out_valid, output out_data);
  modport user_side (output in_valid, output in_data, output out_ready,
                     input in_ready, input out_valid, input out_data);
endinterface
`default_nettype wire

// ===== rtl/dmac_fifo2.sv
`timescale 1ns/1ps
`default_nettype none
`include "dmac_map.svh"
module dmac_fifo2 (
  input wire logic     clk,
  input wire logic     rst,
  dmac_buf_if.buf_side bi
);
  import dmac_pkg::*;

  dmac_fifo_t q;
  dmac_fifo_t n;
  logic       push;
  logic       pop;

  // two-entry ring; full and empty come straight from the count
  always_comb begin
    n = q;
    bi.in_ready = (q.cnt != `DMAC_BUF_DEPTH);
    bi.out_valid = (q.cnt != 2'h0);
    bi.out_data = q.mem[q.rp];
    push = bi.in_valid && bi.in_ready;
    pop = bi.out_valid && bi.out_ready;
    if (push) begin
      n.mem[q.wp] = bi.in_data;
      n.wp = ~q.wp;
    end
    if (pop) begin
      n.rp = ~q.rp;
    end
    n.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // a push into a full buffer would drop a word
  a_buf_no_overflow : assert property (@(posedge clk) disable iff (rst)
    bi.in_valid |-> bi.in_ready) else $error("push into full buffer");
  c_buf_full : cover property (@(posedge clk) disable iff (rst) q.cnt == `DMAC_BUF_DEPTH);
endmodule
`default_nettype wire

// ===== bench/dmac_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module dmac_mem_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [1:0]  lat,
  input  wire logic        bus_req,
  input  wire logic        bus_we,
  input  wire logic [31:0] bus_addr,
  input  wire logic [31:0] bus_wdata,
  output logic [31:0]      bus_rdata,
  output logic             bus_ack
);
  // 4 kbyte of word storage, loaded and inspected by the bench directly
  logic [31:0] mem [0:1023];
  logic [1:0]  wait_q;
  logic [31:0] last_q;

  ////////////////////////////////////////////////////////////////////////////////
  // every request is answered after lat waiting cycles; lat 0 acks in the request cycle
  assign bus_ack   = bus_req && (wait_q == lat);
  // outside a read ack the data lines show the inverse of the value they held at the last ack, so after an odd number of writes the last word read shows again
  assign bus_rdata = (bus_ack && !bus_we) ? mem[bus_addr[11:2]] : ~last_q;

  ////////////////////////////////////////////////////////////////////////////////
  // plain always block: the bench also writes mem between transfers
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_q <= 2'h0;
      last_q <= 32'h0;
    end else if (bus_ack) begin
      wait_q <= 2'h0;
      last_q <= bus_rdata;
      if (bus_we) begin
        mem[bus_addr[11:2]] <= bus_wdata;
      end
    end else if (bus_req) begin
      wait_q <= wait_q + 2'h1;
    end
  end
endmodule
`default_nettype wire

// ===== bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "dmac_map.svh"
module testbench;
  logic        clk;
  logic        rst;
  logic [5:0]  ch_enable;
  logic [5:0]  ch_high_prio;
  logic [5:0]  ch_alt_select;
  logic [5:0]  sw_request;
  logic [7:0]  hw_req;
  logic [31:0] ctrl_base;
  logic        bus_req;
  logic        bus_we;
  logic        bus_ack;
  logic [31:0] bus_addr;
  logic [31:0] bus_wdata;
  logic [31:0] bus_rdata;
  logic [5:0]  dma_done;
  logic [5:0]  ch_alt_active;
  logic        busy;
  logic [2:0]  active_ch;
  logic [1:0]  lat;
  logic [5:0]  prev_done;
  int          fail_count;
  int          cmp_count;
  int          long_pulse;
  int          done_cnt [6];

  dmac_six_ch dmac_six_ch_i (.clk(clk), .rst(rst), .ch_enable(ch_enable),
    .ch_high_prio(ch_high_prio), .ch_alt_select(ch_alt_select), .sw_request(sw_request),
    .sync_port0_tx_request(hw_req[0]), .sync_port0_rx_request(hw_req[1]),
    .sync_port1_tx_request(hw_req[2]), .sync_port1_rx_request(hw_req[3]),
    .serial0_tx_request(hw_req[4]), .serial0_rx_request(hw_req[5]),
    .serial1_tx_request(hw_req[6]), .serial1_rx_request(hw_req[7]),
    .ctrl_base(ctrl_base), .bus_req(bus_req), .bus_we(bus_we), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack), .dma_done(dma_done),
    .ch_alt_active(ch_alt_active), .busy(busy), .active_ch(active_ch));

  dmac_mem_model dmac_mem_model_i (.clk(clk), .rst(rst), .lat(lat), .bus_req(bus_req),
    .bus_we(bus_we), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .bus_ack(bus_ack));

  ////////////////////////////////////////////////////////////////////////////////
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // completion pulses counted per channel; a pulse longer than one clock is flagged
  always @(posedge clk) begin
    if (!rst) begin
      for (int i = 0; i < 6; i++) begin
        if (dma_done[i] === 1'b1) begin
          done_cnt[i]++;
        end
      end
      if ((dma_done & prev_done) !== 6'h0) begin
        long_pulse++;
      end
    end
    prev_done <= dma_done;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("compares %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // control word: dst and src increment on, count stored as n-1
  function automatic logic [31:0] ctl_word(input logic [2:0] t, input int n, input int r);
    return {12'h000, 2'h3, 4'(r), 10'(n - 1), 1'b0, t};
  endfunction

  // word index of a structure; base 0x100, 0x10 per channel, alternate +0x80
  function automatic int widx(input int c, input int a);
    return (256 + a * 128 + c * 16) / 4;
  endfunction

  function automatic logic [31:0] pat(input logic [31:0] src, input int k);
    return 32'h5a000000 + src + 32'(k);
  endfunction

  task automatic setup(input int c, input int a, input logic [2:0] t, input int n,
                       input int r, input logic [31:0] src, input logic [31:0] dst);
    dmac_mem_model_i.mem[widx(c, a) + 2] = ctl_word(t, n, r);
    dmac_mem_model_i.mem[widx(c, a)] = src + 32'(4 * (n - 1));
    dmac_mem_model_i.mem[widx(c, a) + 1] = dst + 32'(4 * (n - 1));
    for (int k = 0; k < n; k++) begin
      dmac_mem_model_i.mem[src / 4 + k] = pat(src, k);
      dmac_mem_model_i.mem[dst / 4 + k] = 32'h0;
    end
  endtask

  task automatic check_dst(input logic [31:0] src, input logic [31:0] dst, input int n);
    for (int k = 0; k < n; k++) begin
      check(dmac_mem_model_i.mem[dst / 4 + k], pat(src, k));
    end
  endtask

  // one-cycle request pulse, software and hardware lines together
  task automatic pulse(input logic [5:0] s, input logic [7:0] h);
    sw_request = s;
    hw_req = h;
    @(posedge clk);
    #1;
    sw_request = 6'h0;
    hw_req = 8'h0;
  endtask

  // bounded wait for the engine to stay idle four cycles (auto bursts idle only one)
  task automatic wait_quiet;
    int q;
    q = 0;
    for (int i = 0; i < 3000 && q < 4; i++) begin
      @(posedge clk);
      #1;
      q = (busy === 1'b0) ? q + 1 : 0;
    end
    if (q < 4) begin
      check(32'(busy), 32'h0);
      end_of_test;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int c;
    int b;
    int tot;
    rst = 1'b1;
    ch_enable = 6'h0;
    ch_high_prio = 6'h0;
    ch_alt_select = 6'h0;
    sw_request = 6'h0;
    hw_req = 8'h0;
    ctrl_base = 32'h100;
    lat = 2'h0;
    prev_done = 6'h0;
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    @(posedge clk);
    #1;
    ch_enable = 6'h1f;
    // every hardware line starts only its own channel
    for (int i = 0; i < 8; i++) begin
      c = i / 2;
      b = done_cnt[c];
      tot = done_cnt.sum();
      setup(c, 0, `DMAC_CC_BASIC, 1, 0, 32'h400, 32'h800 + 32'(i * 4));
      pulse(6'h0, 8'(1 << i));
      wait_quiet;
      check(32'(done_cnt[c]), 32'(b + 1));
      check(32'(done_cnt.sum()), 32'(tot + 1));
      check_dst(32'h400, 32'h800 + 32'(i * 4), 1);
      check(ctl_at(c, 0) & 32'h3ff7, 32'h0);
    end
    // basic, 3 words in bursts of 2: second burst needs a new request
    b = done_cnt[0];
    setup(0, 0, `DMAC_CC_BASIC, 3, 1, 32'h440, 32'h880);
    pulse(6'h0, 8'h01);
    wait_quiet;
    check(32'(done_cnt[0]), 32'(b));
    check(ctl_at(0, 0) & 32'h3ff7, 32'h1);
    check_dst(32'h440, 32'h880, 2);
    check(dmac_mem_model_i.mem[(32'h880 / 4) + 2], 32'h0);
    pulse(6'h01, 8'h0);
    wait_quiet;
    check(32'(done_cnt[0]), 32'(b + 1));
    check_dst(32'h440, 32'h880, 3);
    check(ctl_at(0, 0) & 32'h3ff7, 32'h0);
    // auto-request memory to memory, software start, slow memory
    lat = 2'h2;
    b = done_cnt[4];
    setup(4, 0, `DMAC_CC_AUTO, 5, 1, 32'h480, 32'h8c0);
    pulse(6'h10, 8'h0);
    wait_quiet;
    check(32'(done_cnt[4]), 32'(b + 1));
    check_dst(32'h480, 32'h8c0, 5);
    lat = 2'h0;
    // priority: high channel 4 first, then lowest index when equal
    for (int p = 0; p < 2; p++) begin
      ch_high_prio = (p == 0) ? 6'h08 : 6'h00;
      setup(1, 0, `DMAC_CC_BASIC, 1, 0, 32'h400, 32'h900);
      setup(3, 0, `DMAC_CC_BASIC, 1, 0, 32'h404, 32'h904);
      pulse(6'h0, 8'h44);
      for (int i = 0; i < 10 && bus_req !== 1'b1; i++) begin
        @(posedge clk);
        #1;
      end
      check(bus_addr, (p == 0) ? 32'h138 : 32'h118);
      check(32'(active_ch), (p == 0) ? 32'h3 : 32'h1);
      wait_quiet;
      check_dst(32'h400, 32'h900, 1);
      check_dst(32'h404, 32'h904, 1);
    end
    // disabled channel ignores its request, also after being enabled
    setup(5, 0, `DMAC_CC_BASIC, 1, 0, 32'h400, 32'h920);
    pulse(6'h20, 8'h0);
    b = 0;
    for (int i = 0; i < 40; i++) begin
      ch_enable = (i < 20) ? 6'h1f : 6'h3f;
      @(posedge clk);
      #1;
      b = b + ((busy === 1'b0) ? 0 : 1);
    end
    check(32'(b), 32'h0);
    check(32'(done_cnt[5]), 32'h0);
    pulse(6'h20, 8'h0);
    wait_quiet;
    check(32'(done_cnt[5]), 32'h1);
    // ping-pong: primary then prepared alternate, then primary found invalid
    lat = 2'h1;
    b = done_cnt[2];
    setup(2, 0, `DMAC_CC_PINGPONG, 1, 0, 32'h400, 32'h940);
    setup(2, 1, `DMAC_CC_PINGPONG, 2, 1, 32'h404, 32'h948);
    pulse(6'h04, 8'h0);
    wait_quiet;
    check(32'(done_cnt[2]), 32'(b + 2));
    check(32'(ch_alt_active[2]), 32'h0);
    check_dst(32'h404, 32'h948, 2);
    check(ctl_at(2, 1) & 32'h7, 32'h0);
    // fixed destination: both words land on the end address, the last one stays
    b = done_cnt[5];
    setup(5, 0, `DMAC_CC_BASIC, 2, 1, 32'h400, 32'h960);
    dmac_mem_model_i.mem[widx(5, 0) + 2][`DMAC_DINC_BIT] = 1'b0;
    pulse(6'h20, 8'h0);
    wait_quiet;
    check(dmac_mem_model_i.mem[32'h964 / 4], pat(32'h400, 1));
    check(dmac_mem_model_i.mem[32'h960 / 4], 32'h0);
    // an unknown cycle code runs nothing and signals no completion
    setup(5, 0, 3'h5, 1, 0, 32'h400, 32'h970);
    pulse(6'h20, 8'h0);
    wait_quiet;
    check(32'(done_cnt[5]), 32'(b + 1));
    check(dmac_mem_model_i.mem[32'h970 / 4], 32'h0);
    check(32'(long_pulse), 32'h0);
    end_of_test;
  end

  function automatic logic [31:0] ctl_at(input int c, input int a);
    return dmac_mem_model_i.mem[widx(c, a) + 2];
  endfunction
endmodule
`default_nettype wire
